// >>> rtl/desc_control.sv
// Converter event, interrupt, standby and sync control behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Buffer emptying produces the empty output event.
// - Empty event only while its enable set.
// - Start copies buffer to data, then converts.
// - Start input resynchronised before any use.
// - Start action only while input enable set.
// - Any connected start source triggers the action.
// - Rising edge default, falling when inverted.
// - Converter clock keeps running in idle sleep.
// - Run-in-standby keeps output buffer driving.
// - Otherwise output buffer off during standby.
// - Registers classed by their sync need.
// - Busy bit set at once, cleared when done.
// - Interrupt when flag and its enable set.
// - Request holds until clear, disable or reset.
// - All requests ORed onto one line.
// - Byte, halfword and word accesses supported.
// - Protected registers ignore writes when locked.
module desc_control
   import desc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_EVENT_SRC-1:0] start_event_in,
   input wire logic converter_ready,
   input wire logic standby_sleep,
   input wire logic write_protect,
   output logic [DATA_W-1:0] conversion_data,
   output logic conversion_start,
   output logic empty_event_out,
   output logic output_buffer_enable,
   output logic generic_clock_request,
   output logic irq
);

   // ----------------------------------------------------------------
   // Decoding and merging helpers.
   // ----------------------------------------------------------------

   // Maps a byte address onto a register selector.
   function automatic desc_reg_t decode(input logic [ADDR_W-1:0] addr);
      case (addr)
         ADDR_CONTROL_A: decode = REG_CTRL_A;
         ADDR_EVENT_CONTROL: decode = REG_EVENT_CONTROL_REG;
         ADDR_INT_MASK: decode = REG_MASK;
         ADDR_INT_FLAG: decode = REG_FLAG;
         ADDR_SYNC_BUSY: decode = REG_SYNC;
         ADDR_DATA_BUF: decode = REG_BUF;
         ADDR_DATA: decode = REG_DATA;
         default: decode = REG_NONE;
      endcase
   endfunction

   // Replaces only the byte lanes whose strobe is high.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      merge = res;
   endfunction

   // ----------------------------------------------------------------
   // State declarations.
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] awaddr_q; // Captured write address.
   logic [31:0] wdata_q; // Captured write data.
   logic [3:0] wstrb_q; // Captured byte strobes.
   logic aw_held; // Write address has been taken.
   logic w_held; // Write data has been taken.
   logic write_fire; // Both halves present, write is carried out now.
   desc_reg_t wr_idx; // Target of the pending write.
   desc_reg_t rd_idx; // Target of the arriving read.
   logic read_fire; // Read address taken this cycle.
   logic [CA_W-1:0] ctrl_a; // Control A as software sees it.
   logic [CA_W-1:0] ctrl_active; // Control A as the converter side uses it.
   logic [EV_W-1:0] ev_ctrl; // Event control register.
   logic [NUM_INT-1:0] int_mask; // Interrupt enables.
   logic [NUM_INT-1:0] int_flag; // Sticky interrupt flags.
   logic [NUM_INT-1:0] int_set; // Flag set events this cycle.
   logic int_clear; // Flag read clears all flags.
   logic [DATA_W-1:0] data_buf; // Buffered conversion value.
   logic buf_full; // Buffer holds a value not yet converted.
   logic start_pending; // Accepted start waiting for the converter.
   logic transfer; // Buffer moves to the data register now.
   logic start_accept; // An enabled start edge arrived this cycle.
   logic [NUM_EVENT_SRC-1:0] sync_q1; // First synchroniser stage.
   logic [NUM_EVENT_SRC-1:0] sync_q2; // Second synchroniser stage.
   logic [NUM_EVENT_SRC-1:0] sync_prev; // Previous resynchronised level.
   logic [NUM_EVENT_SRC-1:0] edge_hit; // Qualifying edge per source.
   logic [NUM_SYNC-1:0] sync_busy_bits; // Busy flags per synchronised register.
   logic [NUM_SYNC-1:0] sync_start; // Operation needing synchronisation.
   logic [NUM_SYNC-1:0] sync_done; // Synchronisation ends this cycle.
   logic [31:0] next_ctrl_word; // Merged control A word.
   logic [31:0] next_ev_word; // Merged event control word.
   logic [31:0] next_mask_word; // Merged mask word.
   logic [31:0] next_buf_word; // Merged buffer word.
   logic enable_active; // Converter enabled in its own domain.
   logic run_allowed; // Converter may run in the present sleep state.

   // ----------------------------------------------------------------
   // AXI4-Lite write channel.
   // ----------------------------------------------------------------

   assign write_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx = decode(awaddr_q);
   assign next_ctrl_word = merge(32'(ctrl_a), wdata_q, wstrb_q);
   assign next_ev_word = merge(32'(ev_ctrl), wdata_q, wstrb_q);
   assign next_mask_word = merge(32'(int_mask), wdata_q, wstrb_q);
   assign next_buf_word = merge(32'(data_buf), wdata_q, wstrb_q);

   // Takes address and data in either order and answers once both are in.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         // Address half.
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         // Data half.
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // Response once both halves are held; unmapped gives an error.
         if (write_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_idx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel.
   // ----------------------------------------------------------------

   assign read_fire = s_axi_arvalid && s_axi_arready;
   assign rd_idx = decode(s_axi_araddr);
   assign int_clear = read_fire && (rd_idx == REG_FLAG);

   // Returns the addressed register; narrow fields sit low, upper bits zero.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (read_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= (rd_idx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         case (rd_idx)
            REG_CTRL_A: s_axi_rdata <= 32'(ctrl_a);
            REG_EVENT_CONTROL_REG: s_axi_rdata <= 32'(ev_ctrl);
            REG_MASK: s_axi_rdata <= 32'(int_mask);
            REG_FLAG: s_axi_rdata <= 32'(int_flag);
            REG_SYNC: s_axi_rdata <= 32'(sync_busy_bits);
            REG_BUF: s_axi_rdata <= 32'(data_buf);
            REG_DATA: s_axi_rdata <= 32'(conversion_data);
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Software registers.
   // ----------------------------------------------------------------

   // Control A and event control are locked while write protection is on.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_a <= CA_RESET;
         ev_ctrl <= EV_RESET;
         int_mask <= INT_RESET;
      end
      else if (write_fire)
      begin
         if (wr_idx == REG_CTRL_A && !write_protect)
         begin
            ctrl_a <= next_ctrl_word[CA_W-1:0];
         end
         if (wr_idx == REG_EVENT_CONTROL_REG && !write_protect)
         begin
            ev_ctrl <= next_ev_word[EV_W-1:0];
         end
         if (wr_idx == REG_MASK)
         begin
            int_mask <= next_mask_word[NUM_INT-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Synchronisation busy tracking.
   // ----------------------------------------------------------------

   // Control A and the data buffer need synchronisation on write; the rest none.
   assign sync_start[SYNC_CTRL_BIT] = write_fire && wr_idx == REG_CTRL_A && !write_protect;
   assign sync_start[SYNC_BUF_BIT] = write_fire && wr_idx == REG_BUF;

   generate
      for (genvar s = 0; s < NUM_SYNC; s++)
      begin : g_sync
         logic [SYNC_CNT_W-1:0] cnt; // Cycles spent synchronising.
         assign sync_done[s] = sync_busy_bits[s] && cnt == SYNC_LAST;
         // Busy rises at the write itself and falls when the count completes.
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               sync_busy_bits[s] <= 1'b0;
               cnt <= SYNC_CNT_ZERO;
            end
            else if (sync_start[s])
            begin
               sync_busy_bits[s] <= 1'b1;
               cnt <= SYNC_CNT_ZERO;
            end
            else if (sync_done[s])
            begin
               sync_busy_bits[s] <= 1'b0;
            end
            else if (sync_busy_bits[s])
            begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate

   // The converter side takes the new control value when its sync completes.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_active <= CA_RESET;
      end
      else if (sync_done[SYNC_CTRL_BIT])
      begin
         ctrl_active <= ctrl_a;
      end
   end

   assign enable_active = ctrl_active[CA_ENABLE_BIT];

   // ----------------------------------------------------------------
   // Start event resynchronisation and edge detection.
   // ----------------------------------------------------------------

   // Two-stage synchroniser; only the second stage is looked at.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_q1 <= '0;
         sync_q2 <= '0;
         sync_prev <= '0;
      end
      else
      begin
         sync_q1 <= start_event_in;
         sync_q2 <= sync_q1;
         sync_prev <= sync_q2;
      end
   end

   generate
      for (genvar e = 0; e < NUM_EVENT_SRC; e++)
      begin : g_edge
         // Falling edge when inverted, rising edge otherwise.
         assign edge_hit[e] = ev_ctrl[EV_INVERT_LSB + e] ? (sync_prev[e] && !sync_q2[e])
                                                        : (!sync_prev[e] && sync_q2[e]);
      end
   endgenerate

   // Any source counts; the action is dropped unless enabled.
   assign start_accept = (|edge_hit) && ev_ctrl[EV_START_EI_BIT] && enable_active;

   // ----------------------------------------------------------------
   // Conversion buffer, start and empty event.
   // ----------------------------------------------------------------

   assign transfer = start_pending && converter_ready && enable_active;

   // Holds the accepted start until the converter is ready for it.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         start_pending <= 1'b0;
      end
      else if (start_accept)
      begin
         start_pending <= 1'b1;
      end
      else if (transfer)
      begin
         start_pending <= 1'b0;
      end
   end

   // Buffer write from the bus; transfer copies it and starts conversion.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_buf <= DATA_RESET;
         buf_full <= 1'b0;
         conversion_data <= DATA_RESET;
         conversion_start <= 1'b0;
         empty_event_out <= 1'b0;
      end
      else
      begin
         conversion_start <= transfer;
         empty_event_out <= transfer && buf_full && ev_ctrl[EV_EMPTY_EO_BIT];
         if (transfer)
         begin
            conversion_data <= data_buf;
         end
         if (write_fire && wr_idx == REG_BUF)
         begin
            data_buf <= next_buf_word[DATA_W-1:0];
            buf_full <= 1'b1;
         end
         else if (transfer)
         begin
            buf_full <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flags and request line.
   // ----------------------------------------------------------------

   assign int_set[INT_EMPTY_BIT] = transfer && buf_full;
   assign int_set[INT_OVERRUN_BIT] = start_accept && start_pending;

   // Sticky flags cleared by reading; a new event wins over the clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_flag <= INT_RESET;
         irq <= 1'b0;
      end
      else
      begin
         int_flag <= (int_clear ? INT_RESET : int_flag) | int_set;
         irq <= |(int_flag & int_mask);
      end
   end

   // ----------------------------------------------------------------
   // Sleep handling of clock and output buffer.
   // ----------------------------------------------------------------

   // Idle sleep never stops the clock; standby keeps it only with run-in-standby.
   assign run_allowed = !standby_sleep || ctrl_active[CA_RUN_IN_STANDBY_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         output_buffer_enable <= 1'b0;
         generic_clock_request <= 1'b0;
      end
      else
      begin
         output_buffer_enable <= enable_active && run_allowed;
         generic_clock_request <= enable_active && run_allowed;
      end
   end

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_quiet;
      $stable(start_event_in) [*4];
   endsequence

   sequence s_busy_run;
      sync_busy_bits[SYNC_CTRL_BIT] [*3];
   endsequence

   property p_empty_event;
      (transfer && buf_full && ev_ctrl[EV_EMPTY_EO_BIT]) |=> empty_event_out;
   endproperty
   a_empty_event: assert property (p_empty_event) else $error("empty event missing");

   property p_empty_gate;
      !ev_ctrl[EV_EMPTY_EO_BIT] |=> !empty_event_out;
   endproperty
   a_empty_gate: assert property (p_empty_gate) else $error("empty event not gated");

   property p_transfer;
      transfer |=> conversion_start && conversion_data == $past(data_buf);
   endproperty
   a_transfer: assert property (p_transfer) else $error("buffer not transferred");

   property p_resync;
      s_quiet |-> edge_hit == '0;
   endproperty
   a_resync: assert property (p_resync) else $error("edge without input change");

   property p_start_disabled;
      (!ev_ctrl[EV_START_EI_BIT] && !start_pending) |=> !start_pending;
   endproperty
   a_start_disabled: assert property (p_start_disabled) else $error("start not ignored");

   property p_standby_off;
      (standby_sleep && !ctrl_active[CA_RUN_IN_STANDBY_BIT]) |=> !output_buffer_enable;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("buffer on in standby");

   property p_standby_keep;
      (standby_sleep && ctrl_active[CA_RUN_IN_STANDBY_BIT] && enable_active) |=> output_buffer_enable;
   endproperty
   a_standby_keep: assert property (p_standby_keep) else $error("buffer off in standby");

   property p_sync_busy;
      sync_start[SYNC_CTRL_BIT] |=> s_busy_run;
   endproperty
   a_sync_busy: assert property (p_sync_busy) else $error("busy bit too short");

   property p_irq;
      (|(int_flag & int_mask)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_set_wins;
      (int_set[INT_EMPTY_BIT] && int_clear) |=> int_flag[INT_EMPTY_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag lost on clear");

   property p_protect;
      (write_fire && write_protect) |=> $stable(ctrl_a) && $stable(ev_ctrl);
   endproperty
   a_protect: assert property (p_protect) else $error("protected write taken");

endmodule
`default_nettype wire

// >>> rtl/desc_pkg.sv
// Shared constants and types of the converter event and sync control block.
package desc_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses on the AXI4-Lite bus.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
   localparam logic [7:0] ADDR_EVENT_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_INT_MASK = 8'h08;
   localparam logic [7:0] ADDR_INT_FLAG = 8'h0c;
   localparam logic [7:0] ADDR_SYNC_BUSY = 8'h10;
   localparam logic [7:0] ADDR_DATA_BUF = 8'h14;
   localparam logic [7:0] ADDR_DATA = 8'h18;

   // ----------------------------------------------------------------
   // Field layouts and widths.
   // ----------------------------------------------------------------
   localparam int CA_W = 2;
   localparam int CA_ENABLE_BIT = 0;
   localparam int CA_RUN_IN_STANDBY_BIT = 1;
   localparam int NUM_EVENT_SRC = 2;
   localparam int EV_EMPTY_EO_BIT = 0;
   localparam int EV_START_EI_BIT = 1;
   localparam int EV_INVERT_LSB = 4;
   localparam int EV_W = EV_INVERT_LSB + NUM_EVENT_SRC;
   localparam int NUM_INT = 2;
   localparam int INT_EMPTY_BIT = 0;
   localparam int INT_OVERRUN_BIT = 1;
   localparam int NUM_SYNC = 2;
   localparam int SYNC_CTRL_BIT = 0;
   localparam int SYNC_BUF_BIT = 1;
   localparam int DATA_W = 10;

   // ----------------------------------------------------------------
   // Reset values, timing counts and bus responses.
   // ----------------------------------------------------------------
   localparam logic [CA_W-1:0] CA_RESET = 2'h0;
   localparam logic [EV_W-1:0] EV_RESET = 6'h00;
   localparam logic [NUM_INT-1:0] INT_RESET = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;
   localparam int SYNC_CNT_W = 2;
   localparam logic [SYNC_CNT_W-1:0] SYNC_LAST = 2'h2;
   localparam logic [SYNC_CNT_W-1:0] SYNC_CNT_ZERO = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Decoded register selector.
   typedef enum {REG_CTRL_A, REG_EVENT_CONTROL_REG, REG_MASK, REG_FLAG, REG_SYNC, REG_BUF, REG_DATA,
                 REG_NONE} desc_reg_t;
endpackage

// >>> bench/desc_core_model.sv
// Analog core model that answers each conversion start with a busy spell.
`timescale 1ns/1ps
`default_nettype none
module desc_core_model #(parameter int BUSY = 4)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic conversion_start,
   output logic converter_ready
);
   // Cycles left in the running conversion.
   int cnt;
   // A start loads the busy spell, which then counts down.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt <= 0;
      else if (conversion_start)
         cnt <= BUSY;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // The core takes the next start only once idle; a start in flight already counts as busy.
   assign converter_ready = (cnt == 0) && !conversion_start;
endmodule
`default_nettype wire

// >>> bench/dac_event_sync_control_test.sv
// Self-checking bench of the converter event and sync control block.
`timescale 1ns/1ps
`default_nettype none
module dac_event_sync_control_test
   import desc_pkg::*;
();
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic standby_sleep = 1'h0, write_protect = 1'h0;
   logic [NUM_EVENT_SRC-1:0] start_event_in = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic [31:0] s_axi_rdata, rd_v;
   logic converter_ready, conversion_start, empty_event_out;
   logic output_buffer_enable, generic_clock_request, irq;
   logic [DATA_W-1:0] conversion_data;
   // Counters of the run and of the pulses seen.
   int error_cnt = 0, checked = 0, cyc = 0, starts = 0, empties = 0;

   desc_control dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_event_in, .converter_ready,
      .standby_sleep, .write_protect, .conversion_data, .conversion_start,
      .empty_event_out, .output_buffer_enable, .generic_clock_request, .irq);
   desc_core_model core_u (.aclk, .aresetn, .conversion_start, .converter_ready);

   initial
   begin
      forever #5 aclk = ~aclk;
   end

   // Counts one-cycle pulses and cuts a hang short.
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (conversion_start === 1'h1) starts <= starts + 1;
      if (empty_event_out === 1'h1) empties <= empties + 1;
      if (cyc == 5000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One write; each channel drops its valid at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= (a == ADDR_DATA_BUF && d == 32'h0) ? 4'h1 : 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (s_axi_bvalid !== 1'h1)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, RESP_OKAY);
   endtask

   // One read; data and response are taken at the answering edge.
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (s_axi_rvalid !== 1'h1)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end
      rd_v = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_v, e);
   endtask

   // Sets the event inputs, then counts starts and empty events.
   task automatic ev(input logic [1:0] v, input int es, input int ee);
      int s0, e0;
      s0 = starts;
      e0 = empties;
      @(posedge aclk);
      start_event_in <= v;
      repeat (12) @(posedge aclk);
      chk(starts - s0, es);
      chk(empties - e0, ee);
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rdc(ADDR_INT_FLAG, 32'h0);
      rd(8'h1c);
      chk(rd_r, RESP_SLVERR);
      // A byte lane write merges into the full word.
      wr(ADDR_DATA_BUF, 32'h3ff);
      wr(ADDR_DATA_BUF, 32'h0);
      rdc(ADDR_DATA_BUF, 32'h300);
      wr(ADDR_CONTROL_A, 32'h1);
      rdc(ADDR_SYNC_BUSY, 32'h1);
      repeat (5) @(posedge aclk);
      rdc(ADDR_SYNC_BUSY, 32'h0);
      chk(generic_clock_request, 1'h1);
      chk(output_buffer_enable, 1'h1);
      wr(ADDR_INT_MASK, 32'h3);
      wr(ADDR_EVENT_CONTROL, 32'h3);
      ev(2'h1, 1, 1);
      chk(conversion_data, 32'h300);
      chk(irq, 1'h1);
      rdc(ADDR_INT_FLAG, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h0);
      rdc(ADDR_DATA, 32'h300);
      // Second source alone triggers; stale buffer gives no empty event.
      ev(2'h3, 1, 0);
      // Inverted source 0 starts on its falling edge only.
      wr(ADDR_EVENT_CONTROL, 32'h13);
      wr(ADDR_DATA_BUF, 32'h2a5);
      ev(2'h2, 1, 1);
      chk(conversion_data, 32'h2a5);
      ev(2'h3, 0, 0);
      wr(ADDR_EVENT_CONTROL, 32'h2);
      ev(2'h0, 0, 0);
      wr(ADDR_DATA_BUF, 32'h155);
      ev(2'h1, 1, 0);
      rdc(ADDR_INT_FLAG, 32'h1);
      // A second edge while a start still waits raises the overrun flag.
      start_event_in <= 2'h0;
      repeat (4) @(posedge aclk);
      start_event_in <= 2'h1;
      @(posedge aclk);
      start_event_in <= 2'h3;
      repeat (12) @(posedge aclk);
      rdc(ADDR_INT_FLAG, 32'h2);
      // An empty event in the cycle of the clearing read survives the clear.
      wr(ADDR_DATA_BUF, 32'h0aa);
      start_event_in <= 2'h0;
      repeat (4) @(posedge aclk);
      start_event_in <= 2'h1;
      repeat (2) @(posedge aclk);
      rd(ADDR_INT_FLAG);
      chk(rd_v, 32'h0);
      rdc(ADDR_INT_FLAG, 32'h1);
      wr(ADDR_EVENT_CONTROL, 32'h1);
      ev(2'h0, 0, 0);
      ev(2'h1, 0, 0);
      write_protect <= 1'h1;
      wr(ADDR_EVENT_CONTROL, 32'h3f);
      rdc(ADDR_EVENT_CONTROL, 32'h1);
      write_protect <= 1'h0;
      // Standby keeps the output only with run-in-standby set.
      standby_sleep <= 1'h1;
      wr(ADDR_CONTROL_A, 32'h1);
      repeat (5) @(posedge aclk);
      chk(output_buffer_enable, 1'h0);
      chk(generic_clock_request, 1'h0);
      wr(ADDR_CONTROL_A, 32'h3);
      repeat (5) @(posedge aclk);
      chk(output_buffer_enable, 1'h1);
      chk(generic_clock_request, 1'h1);
      // A reset in mid-run, with the inputs idle so no false edge follows it.
      aresetn <= 1'h0;
      start_event_in <= 2'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      chk(output_buffer_enable, 1'h0);
      rdc(ADDR_CONTROL_A, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
